// [tecd_pkg.sv]
// Constants for the tag option-word store and its decoder
package tecd_pkg;
  // ---------------------------------------------------------------
  // Store geometry
  // ---------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int WORD_CNT = 32;
  localparam int ADDR_W = 5;
  localparam int TOTAL_BITS = 1024;

  // ---------------------------------------------------------------
  // Word indices
  // ---------------------------------------------------------------
  localparam logic [4:0] IDX_UID = 5'h00;
  localparam logic [4:0] IDX_FAB = 5'h01;
  localparam logic [4:0] IDX_CFG = 5'h02;
  localparam logic [4:0] IDX_WLOCK = 5'h03;
  localparam logic [4:0] IDX_RLOCK = 5'h04;
  localparam logic [4:0] IDX_USER_FIRST = 5'h05;
  localparam logic [4:0] IDX_USER_LAST = 5'h1F;
  localparam int UID_FULL_BYTES = 7;

  // ---------------------------------------------------------------
  // Option word fields and reset contents
  // ---------------------------------------------------------------
  localparam int B_FSCI_HI = 31;
  localparam int B_FSCI_LO = 28;
  localparam int B_FWI_HI = 27;
  localparam int B_FWI_LO = 24;
  localparam int B_SYM = 23;
  localparam int B_TAG_848 = 22;
  localparam int B_TAG_424 = 21;
  localparam int B_TAG_212 = 20;
  localparam int B_RDR_848 = 19;
  localparam int B_RDR_424 = 18;
  localparam int B_RDR_212 = 17;
  localparam int B_NO_L4 = 16;
  localparam int B_PEER = 15;
  localparam int B_PU_IRQ = 14;
  localparam int B_ACT_IRQ = 13;
  localparam int B_MODE_HI = 12;
  localparam int B_MODE_LO = 11;
  localparam int B_RX_NCRC = 10;
  localparam int B_RX_BS = 9;
  localparam int B_TX_NCRC = 8;
  localparam int B_TX_BS = 7;
  localparam int B_FDEL_HI = 6;
  localparam int B_FDEL_LO = 5;
  localparam logic [3:0] FSCI_DEFAULT = 4'h2;
  localparam logic [3:0] FWI_DEFAULT = 4'h6;
  localparam logic [31:0] CFG_DEFAULT = 32'h2600_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Modes, answers, delay compensation (13.56 MHz carrier periods)
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TECD_MODE_L4 = 2'b00,
    TECD_MODE_L3 = 2'b01,
    TECD_MODE_FRAMING = 2'b10,
    TECD_MODE_TRANSPARENT = 2'b11
  } tecd_mode_t;

  typedef enum logic [1:0] {
    TECD_ST_OK = 2'b00,
    TECD_ST_READ_ONLY = 2'b01,
    TECD_ST_LOCKED = 2'b10,
    TECD_ST_BLOCKED = 2'b11
  } tecd_status_t;

  localparam logic [3:0] FDEL_CNT_00 = 4'h6;
  localparam logic [3:0] FDEL_CNT_01 = 4'h4;
  localparam logic [3:0] FDEL_CNT_10 = 4'h2;
  localparam logic [3:0] FDEL_CNT_11 = 4'h8;
endpackage : tecd_pkg

// [tecd_top.sv]
// Option-word store, option decoder and transparent pin routing
`timescale 1ns/1ps
`default_nettype none

typedef enum logic [1:0] {
  TECD_INIT = 2'b00,
  TECD_LOAD = 2'b01,
  TECD_RUN = 2'b10
} tecd_state_t;

typedef struct packed {
  tecd_state_t state;
  logic [31:0][31:0] mem;
  logic [31:0] cfg;
  logic irq;
  logic rf_ack;
  logic [31:0] rf_rdata;
  tecd_pkg::tecd_status_t rf_status;
  logic spi_ack;
  logic [31:0] spi_rdata;
  tecd_pkg::tecd_status_t spi_status;
  logic ss_m;
  logic ss_s;
  logic mosi_m;
  logic mosi_s;
  logic clk_m;
  logic clk_s;
  logic dem_m;
  logic dem_s;
} tecd_regs_t;

// How it works
// - Transparent, select high: MOSI drives modulator
// - Transparent: field clock on MISO, demod on IRQ
// - Select low restores ordinary SPI pin use
// - SPI store access allowed under field, transparent
// - Store is 32 words of 32 bits
// - Fixed map: id, fab, options, locks, user
// - Writes to read-only words are refused
// - Writable words refuse writes once locked
// - Lock words only ever gain set bits
// - Word 0 holds low four identifier bytes
// - Bits 31..28 give frame size code
// - Bits 27..24 give frame waiting code
// - Bits 23..17 form the rate byte
// - SAK flags; not-level-four beats peer target
// - Bit 14 raises interrupt after power-up load
// - Bit 13 raises interrupt entering active state, in L3 and L4 modes only
// - Bits 12..11 select operating mode
// - Bit 10: receiver skips CRC check
// - Bit 9: receiver stores raw bit stream
// - Bits 8, 7: transmitter CRC and raw options
// - Coding options gated by mode and FIFO routing
// - Bits 6..5 pick delay compensation count
module tecd_top #(
  parameter logic [31:0] UID_LOW = 32'h1234_5678, // Arbitrary value
  parameter logic [31:0] FAB_INFO = 32'hA5A5_0001 // Arbitrary value
) (
  input wire logic CLK_I, // 10 MHz clock
  input wire logic RST_I, // Async reset, high
  input wire logic CE_I, // Clock enable
  input wire logic SS_N_I, // Select pin, low active
  input wire logic MOSI_I, // MOSI pin
  input wire logic AFE_CLK_I, // Extracted field clock
  input wire logic AFE_DEMOD_I, // Demodulated receive signal
  input wire logic FIELD_I, // Reader field present
  input wire logic SPI_MISO_I, // MISO from serial engine
  input wire logic SPI_MISO_OE_I, // MISO enable from serial engine
  input wire logic ACTIVE_ENTRY_I, // Pulse: entered active state
  input wire logic FIFO_FRAME_I, // Current frame goes via FIFO
  input wire logic IRQ_CLR_I, // Pulse: clear interrupt
  input wire logic RF_REQ_I, // Reader side request
  input wire logic RF_WE_I, // Reader side write
  input wire logic [4:0] RF_ADDR_I, // Reader side word
  input wire logic [31:0] RF_WDATA_I, // Reader side data
  output logic RF_ACK_O, // Reader side answer pulse
  output logic [31:0] RF_RDATA_O, // Reader side read data
  output logic [1:0] RF_STATUS_O, // Reader side status
  input wire logic SPI_REQ_I, // SPI side request
  input wire logic SPI_WE_I, // SPI side write
  input wire logic [4:0] SPI_ADDR_I, // SPI side word
  input wire logic [31:0] SPI_WDATA_I, // SPI side data
  output logic SPI_ACK_O, // SPI side answer pulse
  output logic [31:0] SPI_RDATA_O, // SPI side read data
  output logic [1:0] SPI_STATUS_O, // SPI side status
  output logic SPI_SS_N_O, // Select to serial engine
  output logic SPI_MOSI_O, // MOSI to serial engine
  output logic MISO_O, // MISO pin level
  output logic MISO_OE_O, // MISO pin enable
  output logic IRQ_O, // Interrupt pin
  output logic MOD_ON_O, // Load modulator on
  output logic PROTO_EN_O, // Options applied
  output logic [3:0] FSCI_O, // Frame size code
  output logic [3:0] FWI_O, // Frame waiting code
  output logic [7:0] TA1_O, // Rate byte
  output logic SAK_NO_L4_O, // SAK: no level four
  output logic SAK_PEER_O, // SAK: passive peer
  output logic [1:0] MODE_O, // Operating mode
  output logic RX_NO_CRC_O, // Receiver skips CRC
  output logic RX_BITSTREAM_O, // Receiver raw bits
  output logic TX_NO_CRC_O, // Transmitter no CRC
  output logic TX_BITSTREAM_O, // Transmitter raw bits
  output logic [3:0] FDEL_CNT_O // Delay in carrier periods
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0][31:0] init_image();
    logic [31:0][31:0] m;
    m = {32{tecd_pkg::WORD_ZERO}};
    m[tecd_pkg::IDX_UID] = UID_LOW;
    m[tecd_pkg::IDX_FAB] = FAB_INFO;
    m[tecd_pkg::IDX_CFG] = tecd_pkg::CFG_DEFAULT;
    return m;
  endfunction : init_image

  function automatic tecd_pkg::tecd_status_t wr_check(input logic [4:0] a,
                                                      input logic [31:0] wlock);
    if (a == tecd_pkg::IDX_UID || a == tecd_pkg::IDX_FAB) begin
      return tecd_pkg::TECD_ST_READ_ONLY;
    end
    if (wlock[a]) begin
      return tecd_pkg::TECD_ST_LOCKED;
    end
    return tecd_pkg::TECD_ST_OK;
  endfunction : wr_check

  function automatic logic [31:0] wr_value(input logic [4:0] a, input logic [31:0] old,
                                           input logic [31:0] wd);
    if (a == tecd_pkg::IDX_WLOCK || a == tecd_pkg::IDX_RLOCK) begin
      return old | wd;
    end
    return wd;
  endfunction : wr_value

  localparam tecd_regs_t RESET_VAL = '{
    state: TECD_INIT,
    mem: init_image(),
    cfg: tecd_pkg::WORD_ZERO,
    irq: 1'b0,
    rf_ack: 1'b0,
    rf_rdata: tecd_pkg::WORD_ZERO,
    rf_status: tecd_pkg::TECD_ST_OK,
    spi_ack: 1'b0,
    spi_rdata: tecd_pkg::WORD_ZERO,
    spi_status: tecd_pkg::TECD_ST_OK,
    ss_m: 1'b1,
    ss_s: 1'b1,
    mosi_m: 1'b0,
    mosi_s: 1'b0,
    clk_m: 1'b0,
    clk_s: 1'b0,
    dem_m: 1'b0,
    dem_s: 1'b0
  };

  tecd_regs_t q;
  tecd_regs_t d;
  logic [1:0] mode;
  logic transp;
  logic spi_ok;
  logic rf_take;
  logic spi_take;
  logic irq_set;
  logic code_en;

  // ---------------------------------------------------------------
  // Option decode
  // ---------------------------------------------------------------
  // mode select
  assign mode = q.cfg[tecd_pkg::B_MODE_HI:tecd_pkg::B_MODE_LO];
  assign transp = (mode == tecd_pkg::TECD_MODE_TRANSPARENT) && q.ss_s;
  assign code_en = (q.state == TECD_RUN) && ((mode == tecd_pkg::TECD_MODE_L3) ||
                   (mode == tecd_pkg::TECD_MODE_FRAMING) ||
                   ((mode == tecd_pkg::TECD_MODE_L4) && FIFO_FRAME_I));
  // Field present locks the store to the reader except in these modes
  // SPI access under field
  assign spi_ok = !FIELD_I || (mode == tecd_pkg::TECD_MODE_L3) ||
                  (mode == tecd_pkg::TECD_MODE_TRANSPARENT);
  assign rf_take = (q.state == TECD_RUN) && RF_REQ_I && !q.rf_ack;
  // Reader side wins a shared cycle; SPI simply waits one cycle
  assign spi_take = (q.state == TECD_RUN) && SPI_REQ_I && !q.spi_ack && !rf_take;
  assign irq_set = (q.state == TECD_RUN) && ACTIVE_ENTRY_I && q.cfg[tecd_pkg::B_ACT_IRQ] &&
                   ((mode == tecd_pkg::TECD_MODE_L3) || (mode == tecd_pkg::TECD_MODE_L4));

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    d.rf_ack = 1'b0;
    d.spi_ack = 1'b0;
    d.ss_m = SS_N_I;
    d.ss_s = q.ss_m;
    d.mosi_m = MOSI_I;
    d.mosi_s = q.mosi_m;
    d.clk_m = AFE_CLK_I;
    d.clk_s = q.clk_m;
    d.dem_m = AFE_DEMOD_I;
    d.dem_s = q.dem_m;
    // Set beats a clear arriving in the same cycle
    d.irq = (q.irq && !IRQ_CLR_I) || irq_set;
    unique case (q.state)
      TECD_INIT: begin
        d.state = TECD_LOAD;
      end
      TECD_LOAD: begin
        d.cfg = q.mem[tecd_pkg::IDX_CFG];
        d.state = TECD_RUN;
        if (q.mem[tecd_pkg::IDX_CFG][tecd_pkg::B_PU_IRQ]) begin
          d.irq = 1'b1;
        end
      end
      TECD_RUN: begin
        if (rf_take) begin
          d.rf_ack = 1'b1;
          d.rf_rdata = tecd_pkg::WORD_ZERO;
          d.rf_status = tecd_pkg::TECD_ST_OK;
          if (RF_WE_I) begin
            d.rf_status = wr_check(RF_ADDR_I, q.mem[tecd_pkg::IDX_WLOCK]);
            if (d.rf_status == tecd_pkg::TECD_ST_OK) begin
              d.mem[RF_ADDR_I] = wr_value(RF_ADDR_I, q.mem[RF_ADDR_I], RF_WDATA_I);
            end
          end else if (RF_ADDR_I < tecd_pkg::IDX_USER_FIRST ||
                       !q.mem[tecd_pkg::IDX_RLOCK][RF_ADDR_I]) begin
            d.rf_rdata = q.mem[RF_ADDR_I];
          end
        end
        if (spi_take) begin
          d.spi_ack = 1'b1;
          d.spi_rdata = tecd_pkg::WORD_ZERO;
          d.spi_status = tecd_pkg::TECD_ST_OK;
          if (!spi_ok) begin
            d.spi_status = tecd_pkg::TECD_ST_BLOCKED;
          end else if (SPI_WE_I) begin
            d.spi_status = wr_check(SPI_ADDR_I, q.mem[tecd_pkg::IDX_WLOCK]);
            if (d.spi_status == tecd_pkg::TECD_ST_OK) begin
              d.mem[SPI_ADDR_I] = wr_value(SPI_ADDR_I, q.mem[SPI_ADDR_I], SPI_WDATA_I);
            end
          end else begin
            d.spi_rdata = q.mem[SPI_ADDR_I];
          end
        end
      end
      default: begin
        d.state = TECD_INIT;
      end
    endcase
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      q <= RESET_VAL;
    end else if (CE_I) begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign RF_ACK_O = q.rf_ack;
  assign RF_RDATA_O = q.rf_rdata;
  assign RF_STATUS_O = q.rf_status;
  assign SPI_ACK_O = q.spi_ack;
  assign SPI_RDATA_O = q.spi_rdata;
  assign SPI_STATUS_O = q.spi_status;
  assign SPI_SS_N_O = transp ? 1'b1 : q.ss_s;
  assign SPI_MOSI_O = q.mosi_s;
  assign MOD_ON_O = transp && q.mosi_s;
  assign MISO_O = transp ? q.clk_s : SPI_MISO_I;
  assign MISO_OE_O = transp ? 1'b1 : SPI_MISO_OE_I;
  assign IRQ_O = transp ? q.dem_s : q.irq;
  assign PROTO_EN_O = (q.state == TECD_RUN);
  assign FSCI_O = q.cfg[tecd_pkg::B_FSCI_HI:tecd_pkg::B_FSCI_LO];
  assign FWI_O = q.cfg[tecd_pkg::B_FWI_HI:tecd_pkg::B_FWI_LO];
  assign TA1_O = {q.cfg[tecd_pkg::B_SYM], q.cfg[tecd_pkg::B_TAG_848],
                  q.cfg[tecd_pkg::B_TAG_424], q.cfg[tecd_pkg::B_TAG_212], 1'b0,
                  q.cfg[tecd_pkg::B_RDR_848], q.cfg[tecd_pkg::B_RDR_424],
                  q.cfg[tecd_pkg::B_RDR_212]};
  assign SAK_NO_L4_O = q.cfg[tecd_pkg::B_NO_L4];
  assign SAK_PEER_O = q.cfg[tecd_pkg::B_PEER] && !q.cfg[tecd_pkg::B_NO_L4];
  assign MODE_O = mode;
  assign RX_NO_CRC_O = code_en && q.cfg[tecd_pkg::B_RX_NCRC];
  assign RX_BITSTREAM_O = code_en && q.cfg[tecd_pkg::B_RX_BS];
  assign TX_NO_CRC_O = code_en && q.cfg[tecd_pkg::B_TX_NCRC];
  assign TX_BITSTREAM_O = code_en && q.cfg[tecd_pkg::B_TX_BS];

  always_comb begin
    unique case (q.cfg[tecd_pkg::B_FDEL_HI:tecd_pkg::B_FDEL_LO])
      2'b00: FDEL_CNT_O = tecd_pkg::FDEL_CNT_00;
      2'b01: FDEL_CNT_O = tecd_pkg::FDEL_CNT_01;
      2'b10: FDEL_CNT_O = tecd_pkg::FDEL_CNT_10;
      2'b11: FDEL_CNT_O = tecd_pkg::FDEL_CNT_11;
    endcase
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  sequence s_spi_req_transp;
    CE_I && spi_take && FIELD_I && mode == tecd_pkg::TECD_MODE_TRANSPARENT;
  endsequence
  sequence s_spi_granted;
    SPI_ACK_O && SPI_STATUS_O != tecd_pkg::TECD_ST_BLOCKED;
  endsequence

  property p_mod_follow;
    (mode == tecd_pkg::TECD_MODE_TRANSPARENT && q.ss_s) |-> (MOD_ON_O == q.mosi_s);
  endproperty
  a_mod_follow: assert property (p_mod_follow) else $error("modulator not from MOSI");

  property p_route;
    transp |-> (MISO_O == q.clk_s && MISO_OE_O && IRQ_O == q.dem_s);
  endproperty
  a_route: assert property (p_route) else $error("transparent routing wrong");

  property p_spi_restore;
    !q.ss_s |-> (MISO_O == SPI_MISO_I && !MOD_ON_O && !SPI_SS_N_O);
  endproperty
  a_spi_restore: assert property (p_spi_restore) else $error("SPI pins not restored");

  property p_spi_field;
    s_spi_req_transp |=> s_spi_granted;
  endproperty
  a_spi_field: assert property (p_spi_field) else $error("SPI refused in transparent");

  property p_ro_stable;
    ##1 ($stable(q.mem[tecd_pkg::IDX_UID]) && $stable(q.mem[tecd_pkg::IDX_FAB]));
  endproperty
  a_ro_stable: assert property (p_ro_stable) else $error("read-only word changed");

  property p_locked;
    (CE_I && rf_take && RF_WE_I && RF_ADDR_I == tecd_pkg::IDX_CFG &&
     q.mem[tecd_pkg::IDX_WLOCK][tecd_pkg::IDX_CFG]) |=>
      (RF_STATUS_O == tecd_pkg::TECD_ST_LOCKED && $stable(q.mem[tecd_pkg::IDX_CFG]));
  endproperty
  a_locked: assert property (p_locked) else $error("locked word was written");

  property p_otp;
    ##1 ((q.mem[tecd_pkg::IDX_WLOCK] & $past(q.mem[tecd_pkg::IDX_WLOCK])) ==
         $past(q.mem[tecd_pkg::IDX_WLOCK]));
  endproperty
  a_otp: assert property (p_otp) else $error("lock bit cleared");

  property p_sak;
    SAK_NO_L4_O |-> !SAK_PEER_O;
  endproperty
  a_sak: assert property (p_sak) else $error("SAK precedence wrong");

  property p_pu_irq;
    (CE_I && q.state == TECD_LOAD && q.mem[tecd_pkg::IDX_CFG][tecd_pkg::B_PU_IRQ]) |=>
      (q.irq && q.state == TECD_RUN);
  endproperty
  a_pu_irq: assert property (p_pu_irq) else $error("no power-up interrupt");

  property p_act_irq;
    (CE_I && irq_set) |=> q.irq;
  endproperty
  a_act_irq: assert property (p_act_irq) else $error("no active-entry interrupt");

  property p_load_first;
    (q.state != TECD_RUN) |-> (!PROTO_EN_O && !q.rf_ack && !q.spi_ack);
  endproperty
  a_load_first: assert property (p_load_first) else $error("active before load");

endmodule : tecd_top

`default_nettype wire

// [tecd_req_model.sv]
// Requester model for one word-access port of the option store
`timescale 1ns/1ps
`default_nettype none

module tecd_req_model (
  input wire logic clk_i, // Block clock
  output logic req_o, // Request
  output logic we_o, // Write
  output logic [4:0] addr_o, // Word index
  output logic [31:0] wdata_o, // Write data
  input wire logic ack_i, // Answer pulse
  input wire logic [31:0] rdata_i, // Read data
  input wire logic [1:0] status_i // Answer code
);
  initial begin
    req_o = 1'b0;
    we_o = 1'b0;
    addr_o = 5'h00;
    wdata_o = 32'h0000_0000;
  end

  // ------------------------------------------------------------
  // One word transfer
  // ------------------------------------------------------------
  // Held past the edge that samples the answer; released lines are
  // inverted so a stale value can never pass for a fresh one
  task automatic access(input logic we, input logic [4:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic [1:0] status, output logic ok);
    int n;
    ok = 1'b0;
    rdata = 32'h0000_0000;
    status = 2'h0;
    @(negedge clk_i);
    req_o = 1'b1;
    we_o = we;
    addr_o = addr;
    wdata_o = wdata;
    for (n = 0; n < 16 && !ok; n++) begin
      @(negedge clk_i);
      if (ack_i === 1'b1) begin
        ok = 1'b1;
        rdata = rdata_i;
        status = status_i;
      end
    end
    @(negedge clk_i);
    req_o = 1'b0;
    we_o = ~we;
    addr_o = ~addr;
    wdata_o = ~wdata;
  endtask : access
endmodule : tecd_req_model

`default_nettype wire

// [tag_eeprom_config_decode_tb_top.sv]
// Self-checking bench for the option-word store and decoder
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("Error t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end

module tag_eeprom_config_decode_tb_top;
  localparam logic [31:0] UID_V = 32'h0BAD_F00D; // Arbitrary value
  localparam logic [31:0] FAB_V = 32'h0C0F_FEE5; // Arbitrary value
  logic clk, rst, ce, ss_n, mosi, afe_clk, afe_dem, field, miso_in, miso_oe_in;
  logic act, fifo_fr, irq_clr, rf_req, rf_we, spi_req, spi_we, rf_ack, spi_ack;
  logic [4:0] rf_addr, spi_addr;
  logic [31:0] rf_wd, spi_wd, rf_rd, spi_rd, seed, rd_v;
  logic [1:0] rf_st, spi_st, st_v, mode;
  logic ss_o, mosi_o, miso_o, miso_oe_o, irq_o, mod_o, pen, ok_v;
  logic no_l4, peer, rxn, rxb, txn, txb;
  logic [3:0] fsci, fwi, fdel;
  logic [7:0] ta1;
  logic [31:0] shadow [32];
  int errors, checks_done;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  tecd_top #(.UID_LOW(UID_V), .FAB_INFO(FAB_V)) uut (
    .CLK_I(clk), .RST_I(rst), .CE_I(ce), .SS_N_I(ss_n), .MOSI_I(mosi),
    .AFE_CLK_I(afe_clk), .AFE_DEMOD_I(afe_dem), .FIELD_I(field),
    .SPI_MISO_I(miso_in), .SPI_MISO_OE_I(miso_oe_in), .ACTIVE_ENTRY_I(act),
    .FIFO_FRAME_I(fifo_fr), .IRQ_CLR_I(irq_clr),
    .RF_REQ_I(rf_req), .RF_WE_I(rf_we), .RF_ADDR_I(rf_addr), .RF_WDATA_I(rf_wd),
    .RF_ACK_O(rf_ack), .RF_RDATA_O(rf_rd), .RF_STATUS_O(rf_st),
    .SPI_REQ_I(spi_req), .SPI_WE_I(spi_we), .SPI_ADDR_I(spi_addr), .SPI_WDATA_I(spi_wd),
    .SPI_ACK_O(spi_ack), .SPI_RDATA_O(spi_rd), .SPI_STATUS_O(spi_st),
    .SPI_SS_N_O(ss_o), .SPI_MOSI_O(mosi_o), .MISO_O(miso_o), .MISO_OE_O(miso_oe_o),
    .IRQ_O(irq_o), .MOD_ON_O(mod_o), .PROTO_EN_O(pen), .FSCI_O(fsci), .FWI_O(fwi),
    .TA1_O(ta1), .SAK_NO_L4_O(no_l4), .SAK_PEER_O(peer), .MODE_O(mode),
    .RX_NO_CRC_O(rxn), .RX_BITSTREAM_O(rxb), .TX_NO_CRC_O(txn), .TX_BITSTREAM_O(txb),
    .FDEL_CNT_O(fdel)
  );

  tecd_req_model rf_m (.clk_i(clk), .req_o(rf_req), .we_o(rf_we), .addr_o(rf_addr),
    .wdata_o(rf_wd), .ack_i(rf_ack), .rdata_i(rf_rd), .status_i(rf_st));
  tecd_req_model spi_m (.clk_i(clk), .req_o(spi_req), .we_o(spi_we), .addr_o(spi_addr),
    .wdata_o(spi_wd), .ack_i(spi_ack), .rdata_i(spi_rd), .status_i(spi_st));

  // ------------------------------------------------------------
  // Expectation helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [7:0] exp_ta1(input logic [31:0] c);
    return {c[23:20], 1'b0, c[19:17]};
  endfunction : exp_ta1

  function automatic logic [3:0] exp_fdel(input logic [1:0] f);
    case (f)
      2'b00: return 4'h6;
      2'b01: return 4'h4;
      2'b10: return 4'h2;
      default: return 4'h8;
    endcase
  endfunction : exp_fdel

  // ------------------------------------------------------------
  // Run control and transfers
  // ------------------------------------------------------------
  task automatic final_report();
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic xfer(input bit spi, input logic we, input logic [4:0] a, input logic [31:0] d);
    if (spi) spi_m.access(we, a, d, rd_v, st_v, ok_v);
    else rf_m.access(we, a, d, rd_v, st_v, ok_v);
    if (ok_v !== 1'b1) begin
      errors++;
      final_report();
    end
  endtask : xfer

  // Store contents come back to their initial image, with user words zero, so the shadow is cleared
  task automatic do_reset();
    int n;
    rst = 1'b1;
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (n = 0; n < 32; n++) shadow[n] = 32'h0000_0000;
    for (n = 0; n < 10 && pen !== 1'b1; n++) @(negedge clk);
    if (pen !== 1'b1) begin
      errors++;
      final_report();
    end
  endtask : do_reset

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int k;
    logic [4:0] a;
    rst = 1'b1;
    ce = 1'b1;
    ss_n = 1'b0;
    mosi = 1'b0;
    afe_clk = 1'b0;
    afe_dem = 1'b0;
    field = 1'b0;
    miso_in = 1'b0;
    miso_oe_in = 1'b0;
    act = 1'b0;
    fifo_fr = 1'b1;
    irq_clr = 1'b0;
    errors = 0;
    checks_done = 0;
    seed = 32'h0000_003F;
    do_reset();
    `CHK(fsci, 4'h2);
    `CHK(fwi, 4'h6);
    `CHK(ta1, exp_ta1(tecd_pkg::CFG_DEFAULT));
    `CHK({no_l4, peer}, 2'b00);
    `CHK(mode, 2'b00);
    `CHK({rxn, rxb, txn, txb}, 4'h0);
    `CHK(fdel, exp_fdel(tecd_pkg::CFG_DEFAULT[6:5]));
    `CHK(irq_o, 1'b0);
    for (k = 0; k < 2; k++) begin
      xfer(k[0], 1'b0, 5'h00, 32'h0000_0000);
      `CHK(rd_v, UID_V);
      xfer(k[0], 1'b0, 5'h01, 32'h0000_0000);
      `CHK(rd_v, FAB_V);
      xfer(k[0], 1'b0, 5'h02, 32'h0000_0000);
      `CHK(rd_v, 32'h2600_0000);
      xfer(k[0], 1'b1, 5'(k), ~rd_v);
      `CHK(st_v, 2'h1);
    end
    xfer(1'b1, 1'b0, 5'h00, 32'h0000_0000);
    `CHK(rd_v, UID_V);
    // Edge words first, then random spread over the user area
    for (k = 0; k < 40; k++) begin
      seed = xs(seed);
      a = (k == 0) ? 5'h05 : (k == 1) ? 5'h1F : 5'(32'd5 + seed % 32'd27);
      seed = xs(seed);
      xfer(seed[3], 1'b1, a, seed);
      `CHK(st_v, 2'h0);
      shadow[a] = seed;
    end
    for (k = 5; k < 32; k++) begin
      xfer(k[0], 1'b0, 5'(k), 32'h0000_0000);
      `CHK(rd_v, shadow[k]);
    end
    xfer(1'b1, 1'b1, 5'h04, 32'h0000_0100);
    xfer(1'b0, 1'b1, 5'h04, 32'h0000_0020);
    xfer(1'b1, 1'b0, 5'h04, 32'h0000_0000);
    `CHK(rd_v, 32'h0000_0120);
    xfer(1'b0, 1'b0, 5'h08, 32'h0000_0000);
    `CHK(rd_v, 32'h0000_0000);
    xfer(1'b1, 1'b0, 5'h08, 32'h0000_0000);
    `CHK(rd_v, shadow[8]);
    xfer(1'b0, 1'b1, 5'h03, 32'h0000_0020);
    xfer(1'b0, 1'b1, 5'h03, 32'h0000_0000);
    xfer(1'b1, 1'b0, 5'h03, 32'h0000_0000);
    `CHK(rd_v, 32'h0000_0020);
    xfer(1'b1, 1'b1, 5'h05, ~shadow[5]);
    `CHK(st_v, 2'h2);
    xfer(1'b1, 1'b0, 5'h05, 32'h0000_0000);
    `CHK(rd_v, shadow[5]);
    field = 1'b1;
    xfer(1'b1, 1'b1, 5'h06, ~shadow[6]);
    `CHK(st_v, 2'h3);
    xfer(1'b0, 1'b0, 5'h06, 32'h0000_0000);
    `CHK(rd_v, shadow[6]);
    field = 1'b0;
    // Outside transparent mode the pins keep their serial meaning
    ss_n = 1'b1;
    mosi = 1'b1;
    afe_dem = 1'b1;
    miso_in = 1'b1;
    miso_oe_in = 1'b1;
    act = 1'b1;
    @(negedge clk);
    act = 1'b0;
    irq_clr = 1'b1;
    @(negedge clk);
    irq_clr = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(mod_o, 1'b0);
    `CHK(irq_o, 1'b0);
    `CHK({ss_o, mosi_o, miso_o, miso_oe_o}, 4'hF);
    // Clock enable low freezes the pin synchronisers
    ce = 1'b0;
    ss_n = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(ss_o, 1'b1);
    ce = 1'b1;
    ss_n = 1'b0;
    mosi = 1'b0;
    miso_in = 1'b0;
    repeat (3) @(negedge clk);
    `CHK({ss_o, mosi_o, miso_o, miso_oe_o}, 4'h1);
    // Lock bit 2 protects the option word from further writes
    xfer(1'b1, 1'b1, 5'h03, 32'h0000_0004);
    `CHK(st_v, 2'h0);
    xfer(1'b0, 1'b1, 5'h02, 32'h0000_0000);
    `CHK(st_v, 2'h2);
    xfer(1'b1, 1'b0, 5'h02, 32'h0000_0000);
    `CHK(rd_v, 32'h2600_0000);
    // Mid-run reset reloads the options from the initial store image
    do_reset();
    `CHK(fsci, 4'h2);
    xfer(1'b1, 1'b0, 5'h1F, 32'h0000_0000);
    `CHK(rd_v, 32'h0000_0000);
    final_report();
  end
endmodule : tag_eeprom_config_decode_tb_top

`default_nettype wire
